//--- hdl/lpcf_link_channel.sv
// lpcf_link_channel.sv: per-link traffic class steering, credits, arbiter
// assumes: one core clock, async active-low cold reset, warm_reset pulse,
// a producer that checks slot_free before raising in_valid
`timescale 1ns/10ps
`include "lpcf_defines.svh"

module lpcf_link_channel
    import lpcf_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        warm_reset,
    // receive stream
    input  wire logic        in_valid,
    input  wire lpcf_kind_t  in_kind,
    input  wire logic        in_lat,
    input  wire logic        in_pass,
    input  wire logic [31:0] in_data,
    output logic [5:0]       slot_free,
    // transmit stream
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic [2:0]       out_slot,
    output logic             out_lat,
    output logic             out_pass,
    output logic [31:0]      out_data,
    // credits returned by far side
    input  wire logic        cred_valid,
    input  wire logic        cred_lat,
    input  wire lpcf_vc_t    cred_vc,
    // buffer release idle packets
    output logic             nop_valid,
    output logic             nop_lat,
    output lpcf_vc_t         nop_vc,
    // AXI4-Lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ---------------------------------------------------------------
    // functions
    // ---------------------------------------------------------------
    function automatic logic [2:0] slot_of(input logic hp, input lpcf_vc_t vc);
        logic [2:0] base;
        base = hp ? `LPCF_HP_BASE : `LPCF_ORD_BASE;
        slot_of = base + {1'b0, vc};
    endfunction

    function automatic logic known_reg(input logic [3:0] a);
        known_reg = (a == `LPCF_OFF_CTRL) || (a == `LPCF_OFF_STATUS) ||
                    (a == `LPCF_OFF_FAIR) || (a == `LPCF_OFF_CREDIT);
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic        hp_enable;
    logic        pass_all;
    logic        hp_active;
    logic [31:0] fair_count;
    logic [5:0]  slot_v;
    logic [5:0]  slot_lat;
    logic [5:0]  slot_pass;
    logic [31:0] slot_data [6];
    logic [`LPCF_CREDIT_W-1:0] credit [6];
    lpcf_wr_t    wr_state;
    logic        aw_held;
    logic        w_held;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    // ---------------------------------------------------------------
    // mode control
    // ---------------------------------------------------------------
    // enable latched only by warm reset; one instance per link
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hp_active <= 1'b0;
        end else if (warm_reset) begin
            hp_active <= hp_enable;
        end
    end

    // ---------------------------------------------------------------
    // receive steering
    // ---------------------------------------------------------------
    lpcf_vc_t   in_vc;
    logic       in_hp;
    logic [2:0] in_slot;
    logic       in_take;

    always_comb begin
        case (in_kind)
            LPCF_PKT_POSTED, LPCF_PKT_SPECIAL_P: in_vc = LPCF_VC_POSTED;
            LPCF_PKT_NONPOSTED, LPCF_PKT_SPECIAL_NP: in_vc = LPCF_VC_NONPOSTED;
            default: in_vc = LPCF_VC_RESPONSE;
        endcase
        // special packets stay ordinary; off mode maps all to ordinary
        in_hp = hp_active && in_lat && (in_kind != LPCF_PKT_SPECIAL_P) &&
                (in_kind != LPCF_PKT_SPECIAL_NP);
        in_slot = slot_of(in_hp, in_vc);
        in_take = in_valid && !slot_v[in_slot];
    end

    // ---------------------------------------------------------------
    // arbiter
    // ---------------------------------------------------------------
    logic       pick_v;
    logic [2:0] pick;
    logic       load;

    always_comb begin
        logic [2:0] b;
        logic       ok_p;
        logic       ok_n;
        logic       ok_r;
        pick_v = 1'b0;
        pick = `LPCF_ORD_BASE;
        b = `LPCF_ORD_BASE;
        ok_p = 1'b0;
        ok_n = 1'b0;
        ok_r = 1'b0;
        // classes are independent; high class checked last so it wins
        for (int c = 0; c < 2; c++) begin
            b = (c == 1) ? `LPCF_HP_BASE : `LPCF_ORD_BASE;
            ok_p = slot_v[b] && (credit[b] != '0);
            ok_n = slot_v[b+3'h1] && (credit[b+3'h1] != '0);
            ok_r = slot_v[b+3'h2] && (credit[b+3'h2] != '0);
            // same order inside each class
            if (ok_r && slot_pass[b+3'h2]) begin
                pick_v = 1'b1;
                pick = b + 3'h2;
            end else if (ok_p) begin
                pick_v = 1'b1;
                pick = b;
            end else if (ok_r && !slot_v[b]) begin
                pick_v = 1'b1;
                pick = b + 3'h2;
            end else if (ok_n && !slot_v[b]) begin
                pick_v = 1'b1;
                pick = b + 3'h1;
            end
        end
        load = pick_v && (!out_valid || out_ready);
    end

    // ---------------------------------------------------------------
    // virtual channel buffers and credits
    // ---------------------------------------------------------------
    logic [5:0] next_slot_v;
    lpcf_vc_t   cred_slot_vc;
    logic [2:0] cred_slot;

    assign cred_slot_vc = cred_vc;
    assign cred_slot = slot_of(hp_active && cred_lat, cred_slot_vc);

    generate
        for (genvar i = 0; i < `LPCF_NUM_SLOTS; i++) begin : g_slot
            always_comb begin
                next_slot_v[i] = slot_v[i];
                if (load && pick == i[2:0]) begin
                    next_slot_v[i] = 1'b0;
                end
                if (in_take && in_slot == i[2:0]) begin
                    next_slot_v[i] = 1'b1;
                end
            end

            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    slot_v[i] <= 1'b0;
                    slot_lat[i] <= 1'b0;
                    slot_pass[i] <= 1'b0;
                    slot_data[i] <= '0;
                end else begin
                    slot_v[i] <= next_slot_v[i];
                    if (in_take && in_slot == i[2:0]) begin
                        // latency flag kept as received; local replies carry request flag
                        slot_lat[i] <= in_lat;
                        slot_pass[i] <= in_pass;
                        slot_data[i] <= in_data;
                    end
                end
            end

            // per channel transmit credits
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    credit[i] <= `LPCF_CREDIT_INIT;
                end else begin
                    logic inc;
                    logic dec;
                    inc = cred_valid && cred_slot == i[2:0] &&
                          credit[i] != `LPCF_CREDIT_MAX;
                    dec = load && pick == i[2:0];
                    if (inc && !dec) begin
                        credit[i] <= credit[i] + 1'b1;
                    end else if (dec && !inc) begin
                        credit[i] <= credit[i] - 1'b1;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            slot_free <= '1;
        end else begin
            slot_free <= ~next_slot_v;
        end
    end

    // ---------------------------------------------------------------
    // transmit register and idle packets
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            out_valid <= 1'b0;
            out_slot <= '0;
            out_lat <= 1'b0;
            out_pass <= 1'b0;
            out_data <= '0;
        end else if (load) begin
            out_valid <= 1'b1;
            out_slot <= pick;
            out_lat <= slot_lat[pick];
            out_pass <= slot_pass[pick] ||
                        (pass_all && pick[1:0] == LPCF_VC_RESPONSE &&
                         pick < `LPCF_HP_BASE) ||
                        (pass_all && pick == `LPCF_HP_BASE + 3'h2);
            out_data <= slot_data[pick];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

    // a freed receive buffer is announced to the far side
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            nop_valid <= 1'b0;
            nop_lat <= 1'b0;
            nop_vc <= LPCF_VC_POSTED;
        end else begin
            nop_valid <= load;
            nop_lat <= load && hp_active && (pick >= `LPCF_HP_BASE);
            nop_vc <= (pick >= `LPCF_HP_BASE) ? lpcf_vc_t'(2'(pick - `LPCF_HP_BASE))
                                             : lpcf_vc_t'(pick[1:0]);
        end
    end

    // ordinary sends only
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fair_count <= '0;
        end else if (load && pick < `LPCF_HP_BASE) begin
            fair_count <= fair_count + 32'h1;
        end
    end

    // ---------------------------------------------------------------
    // AXI4-Lite write
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wr_state <= LPCF_WR_IDLE;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LPCF_RESP_OKAY;
            hp_enable <= 1'b0;
            pass_all <= 1'b0;
        end else begin
            case (wr_state)
                LPCF_WR_IDLE: begin
                    s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
                    s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
                    if (s_axi_awvalid && s_axi_awready) begin
                        aw_held <= 1'b1;
                        aw_addr <= s_axi_awaddr;
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        w_held <= 1'b1;
                        w_data <= s_axi_wdata;
                        w_strb <= s_axi_wstrb;
                    end
                    if (aw_held && w_held) begin
                        s_axi_awready <= 1'b0;
                        s_axi_wready <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= known_reg(aw_addr) ? `LPCF_RESP_OKAY
                                                          : `LPCF_RESP_SLVERR;
                        if (aw_addr == `LPCF_OFF_CTRL && w_strb[0]) begin
                            hp_enable <= w_data[`LPCF_CTRL_HP_EN];
                            pass_all <= w_data[`LPCF_CTRL_PASS_ALL];
                        end
                        wr_state <= LPCF_WR_RESP;
                    end
                end
                LPCF_WR_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        aw_held <= 1'b0;
                        w_held <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready <= 1'b1;
                        wr_state <= LPCF_WR_IDLE;
                    end
                end
                default: wr_state <= LPCF_WR_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // AXI4-Lite read
    // ---------------------------------------------------------------
    logic [31:0] rd_word;

    always_comb begin
        rd_word = '0;
        case (s_axi_araddr)
            `LPCF_OFF_CTRL: begin
                rd_word[`LPCF_CTRL_HP_EN] = hp_enable;
                rd_word[`LPCF_CTRL_PASS_ALL] = pass_all;
            end
            `LPCF_OFF_STATUS: begin
                rd_word[`LPCF_STAT_HP_ACT] = hp_active;
                rd_word[`LPCF_STAT_OCC_LO +: 6] = slot_v;
            end
            `LPCF_OFF_FAIR: rd_word = fair_count;
            `LPCF_OFF_CREDIT: rd_word = {8'h00, credit[5], credit[4], credit[3],
                                         credit[2], credit[1], credit[0]};
            default: rd_word = '0;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `LPCF_RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= known_reg(s_axi_araddr) ? `LPCF_RESP_OKAY
                                                   : `LPCF_RESP_SLVERR;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule

//--- hdl/lpcf_defines.svh
// lpcf_defines.svh: offsets, field positions, reset values, counts
// assumes: included by bare name, one 32-bit AXI4-Lite register space
`ifndef LPCF_DEFINES_SVH
`define LPCF_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define LPCF_OFF_CTRL    4'h0
`define LPCF_OFF_STATUS  4'h4
`define LPCF_OFF_FAIR    4'h8
`define LPCF_OFF_CREDIT  4'hC

// ---------------------------------------------------------------
// fields and values
// ---------------------------------------------------------------
`define LPCF_CTRL_HP_EN    0
`define LPCF_CTRL_PASS_ALL 1
`define LPCF_STAT_HP_ACT   0
`define LPCF_STAT_OCC_LO   8
`define LPCF_CREDIT_INIT   4'h4
`define LPCF_CREDIT_MAX    4'hF
`define LPCF_CREDIT_W      4
`define LPCF_NUM_SLOTS     6
`define LPCF_HP_BASE       3'h3
`define LPCF_ORD_BASE      3'h0
`define LPCF_RESP_OKAY     2'h0
`define LPCF_RESP_SLVERR   2'h2

`endif

//--- hdl/lpcf_pkg.sv
// lpcf_pkg.sv: types shared by the link channel logic
// assumes: lpcf_defines.svh for numbers
package lpcf_pkg;

    // packet kinds seen on the receive stream
    typedef enum logic [2:0] {
        LPCF_PKT_POSTED,
        LPCF_PKT_NONPOSTED,
        LPCF_PKT_RESPONSE,
        LPCF_PKT_SPECIAL_P,
        LPCF_PKT_SPECIAL_NP,
        LPCF_PKT_LOCAL_REPLY
    } lpcf_kind_t;

    // virtual channel within a class
    typedef enum logic [1:0] {
        LPCF_VC_POSTED,
        LPCF_VC_NONPOSTED,
        LPCF_VC_RESPONSE
    } lpcf_vc_t;

    typedef enum logic {
        LPCF_WR_IDLE,
        LPCF_WR_RESP
    } lpcf_wr_t;

endpackage

//--- dv/lpcf_link_channel_asserts.sv
// lpcf_link_channel_asserts.sv: port level checks on the link channel
// assumes: bound to lpcf_link_channel from the bench top file
`timescale 1ns/10ps
module lpcf_link_channel_asserts
    import lpcf_pkg::*;
(
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        in_valid,
    input wire lpcf_kind_t  in_kind,
    input wire logic [5:0]  slot_free,
    input wire logic        out_valid,
    input wire logic        out_ready,
    input wire logic [2:0]  out_slot,
    input wire logic        out_lat,
    input wire logic [31:0] out_data,
    input wire logic        nop_valid,
    input wire logic        nop_lat,
    input wire lpcf_vc_t    nop_vc,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!nrst);

    a_out_hold: assert property (out_valid && !out_ready |=> out_valid
        && $stable(out_slot) && $stable(out_lat) && $stable(out_data))
        else $error("out packet changed while stalled");
    a_nop_with_out: assert property (nop_valid |-> out_valid)
        else $error("release pulse without packet");
    a_nop_flag: assert property (nop_valid |-> nop_lat == (out_slot >= 3'h3))
        else $error("release flag does not match class");
    a_nop_channel: assert property (nop_valid |-> nop_vc == lpcf_vc_t'(2'(out_slot % 3'h3)))
        else $error("release channel does not match slot");
    a_slot_range: assert property (out_valid |-> out_slot <= 3'h5)
        else $error("slot out of range");
    a_special_low: assert property (in_valid && in_kind == LPCF_PKT_SPECIAL_P
        && slot_free[0] |-> ##1 !slot_free[0])
        else $error("special packet not in ordinary posted slot");
    a_aw_once: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address ready held after take");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
        && !s_axi_arready)
        else $error("read answer late");
endmodule

//--- dv/lpcf_far_end.sv
// lpcf_far_end.sv: far side of the link, sinks packets and returns credits
// assumes: bench drives stall; one credit back per packet taken
`timescale 1ns/10ps
module lpcf_far_end
    import lpcf_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       stall,
    input  wire logic       out_valid,
    input  wire logic [2:0] out_slot,
    output logic            out_ready,
    output logic            cred_valid,
    output logic            cred_lat,
    output lpcf_vc_t        cred_vc
);
    assign out_ready = !stall;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cred_valid <= 1'b0;
            cred_lat   <= 1'b0;
            cred_vc    <= LPCF_VC_POSTED;
        end else if (out_valid && out_ready) begin
            cred_valid <= 1'b1;
            cred_lat   <= (out_slot >= 3'h3);
            cred_vc    <= lpcf_vc_t'(2'(out_slot % 3'h3));
        end else begin
            cred_valid <= 1'b0;
            cred_lat   <= !cred_lat;
        end
    end
endmodule

//--- dv/testbench.sv
// testbench.sv: self-checking bench for lpcf_link_channel
// assumes: far end model lpcf_far_end, checker bound at the foot
`timescale 1ns/10ps
`include "lpcf_defines.svh"
module testbench
    import lpcf_pkg::*;
;
    typedef struct {
        logic [1:0] ctrl;
        lpcf_kind_t k;
        logic       l;
        logic       p;
        logic [2:0] s;
        logic       ep;
    } lpcf_row_t;

    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic        warm_reset = 1'b0;
    logic        in_valid = 1'b0;
    lpcf_kind_t  in_kind = LPCF_PKT_POSTED;
    logic        in_lat = 1'b0;
    logic        in_pass = 1'b0;
    logic [31:0] in_data = 32'h0;
    logic        stall = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic [3:0]  s_axi_araddr = 4'h0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [5:0]  slot_free;
    logic        out_valid, out_ready, out_lat, out_pass, nop_valid, nop_lat;
    logic        cred_valid, cred_lat, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [2:0]  out_slot;
    logic [31:0] out_data, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    lpcf_vc_t    nop_vc, cred_vc;
    logic [1:0]  ctrl_now = 2'h3;
    int          num_errors = 0;
    int          checks = 0;
    int          fair = 0;
    int          cycles = 0;

    lpcf_row_t rows[12] = '{
        '{2'h0, LPCF_PKT_POSTED, 1'b1, 1'b0, 3'h0, 1'b0},
        '{2'h0, LPCF_PKT_RESPONSE, 1'b1, 1'b1, 3'h2, 1'b1},
        '{2'h1, LPCF_PKT_POSTED, 1'b0, 1'b0, 3'h0, 1'b0},
        '{2'h1, LPCF_PKT_POSTED, 1'b1, 1'b0, 3'h3, 1'b0},
        '{2'h1, LPCF_PKT_NONPOSTED, 1'b1, 1'b0, 3'h4, 1'b0},
        '{2'h1, LPCF_PKT_RESPONSE, 1'b1, 1'b0, 3'h5, 1'b0},
        '{2'h1, LPCF_PKT_LOCAL_REPLY, 1'b1, 1'b0, 3'h5, 1'b0},
        '{2'h1, LPCF_PKT_SPECIAL_P, 1'b1, 1'b0, 3'h0, 1'b0},
        '{2'h1, LPCF_PKT_SPECIAL_NP, 1'b1, 1'b0, 3'h1, 1'b0},
        '{2'h1, LPCF_PKT_NONPOSTED, 1'b0, 1'b0, 3'h1, 1'b0},
        '{2'h3, LPCF_PKT_RESPONSE, 1'b0, 1'b0, 3'h2, 1'b1},
        '{2'h3, LPCF_PKT_RESPONSE, 1'b1, 1'b0, 3'h5, 1'b1}
    };

    lpcf_link_channel i_dut (
        .clock, .nrst, .warm_reset, .in_valid, .in_kind, .in_lat, .in_pass, .in_data,
        .slot_free, .out_valid, .out_ready, .out_slot, .out_lat, .out_pass, .out_data,
        .cred_valid, .cred_lat, .cred_vc, .nop_valid, .nop_lat, .nop_vc,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );

    lpcf_far_end i_far (
        .clock, .nrst, .stall, .out_valid, .out_slot, .out_ready, .cred_valid,
        .cred_lat, .cred_vc
    );

    always #5 clock = ~clock;

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic axi_wr(logic [3:0] a, logic [31:0] d, logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                check("bresp", 32'(s_axi_bresp), 32'(er));
                s_axi_bready <= 1'b0;
            end
        end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
    endtask

    task automatic axi_rd(logic [3:0] a, logic [31:0] exp, logic [31:0] m, logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                check("rdata", s_axi_rdata & m, exp);
                check("rresp", 32'(s_axi_rresp), 32'(er));
                s_axi_rready <= 1'b0;
            end
        end while (s_axi_arvalid || s_axi_rready);
    endtask

    task automatic set_mode(logic [1:0] c);
        axi_wr(`LPCF_OFF_CTRL, 32'(c), `LPCF_RESP_OKAY);
        warm_reset <= 1'b1;
        @(posedge clock);
        warm_reset <= 1'b0;
        @(posedge clock);
        axi_rd(`LPCF_OFF_STATUS, 32'(c[0]), 32'h1, `LPCF_RESP_OKAY);
        ctrl_now = c;
    endtask

    task automatic send(lpcf_kind_t k, logic l, logic p, logic [31:0] d);
        in_kind <= k;
        in_lat <= l;
        in_pass <= p;
        in_data <= d;
        in_valid <= 1'b1;
        @(posedge clock);
    endtask

    task automatic take(logic [2:0] es, logic el, logic ep, logic [31:0] ed, logic nop);
        in_valid <= 1'b0;
        @(posedge clock);
        while (!(out_valid && out_ready))
            @(posedge clock);
        check("out_slot", 32'(out_slot), 32'(es));
        check("out_lat", 32'(out_lat), 32'(el));
        check("out_pass", 32'(out_pass), 32'(ep));
        check("out_data", out_data, ed);
        if (nop) begin
            check("nop_valid", 32'(nop_valid), 32'h1);
            check("nop_lat", 32'(nop_lat), 32'(es >= 3'h3));
            check("nop_vc", 32'(nop_vc), 32'(es % 3'h3));
        end
        if (es < 3'h3)
            fair++;
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clock);
        check("slot_free", 32'(slot_free), 32'h3F);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        axi_rd(`LPCF_OFF_CREDIT, 32'h00444444, 32'hFFFFFFFF, `LPCF_RESP_OKAY);
        axi_wr(`LPCF_OFF_CTRL, 32'h1, `LPCF_RESP_OKAY);
        axi_rd(`LPCF_OFF_STATUS, 32'h0, 32'h1, `LPCF_RESP_OKAY);
        foreach (rows[i]) begin
            if (rows[i].ctrl !== ctrl_now)
                set_mode(rows[i].ctrl);
            send(rows[i].k, rows[i].l, rows[i].p, 32'h100 + 32'(i));
            take(rows[i].s, rows[i].l, rows[i].ep, 32'h100 + 32'(i), 1'b1);
        end
        // stalled far side, mixed classes queued
        set_mode(2'h1);
        stall <= 1'b1;
        send(LPCF_PKT_POSTED, 1'b0, 1'b0, 32'hA);
        send(LPCF_PKT_NONPOSTED, 1'b0, 1'b0, 32'hB);
        send(LPCF_PKT_NONPOSTED, 1'b1, 1'b0, 32'hC);
        send(LPCF_PKT_POSTED, 1'b0, 1'b0, 32'hD);
        send(LPCF_PKT_RESPONSE, 1'b0, 1'b1, 32'hE);
        in_valid <= 1'b0;
        repeat (4) @(posedge clock);
        check("out_valid", 32'(out_valid), 32'h1);
        stall <= 1'b0;
        take(3'h0, 1'b0, 1'b0, 32'hA, 1'b0);
        take(3'h4, 1'b1, 1'b0, 32'hC, 1'b0);
        take(3'h2, 1'b0, 1'b1, 32'hE, 1'b0);
        take(3'h0, 1'b0, 1'b0, 32'hD, 1'b0);
        take(3'h1, 1'b0, 1'b0, 32'hB, 1'b0);
        repeat (5) @(posedge clock);
        axi_rd(`LPCF_OFF_FAIR, 32'(fair), 32'hFFFFFFFF, `LPCF_RESP_OKAY);
        axi_rd(`LPCF_OFF_CREDIT, 32'h00444444, 32'hFFFFFFFF, `LPCF_RESP_OKAY);
        axi_rd(4'h2, 32'h0, 32'hFFFFFFFF, `LPCF_RESP_SLVERR);
        axi_wr(4'h2, 32'h0, `LPCF_RESP_SLVERR);
        // cold reset mid-run drops the mode and empties buffers
        nrst <= 1'b0;
        @(posedge clock);
        check("rst_slot_free", 32'(slot_free), 32'h3F);
        check("rst_out_valid", 32'(out_valid), 32'h0);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
        axi_rd(`LPCF_OFF_STATUS, 32'h0, 32'h1, `LPCF_RESP_OKAY);
        end_sim;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            end_sim;
        end
    end
endmodule

bind lpcf_link_channel lpcf_link_channel_asserts i_chk (
    .clock, .nrst, .in_valid, .in_kind, .slot_free, .out_valid, .out_ready, .out_slot,
    .out_lat, .out_data, .nop_valid, .nop_lat, .nop_vc, .s_axi_awvalid, .s_axi_awready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid
);
